// file: sdc_pkg.sv
// constants, command layout and response layout for the solenoid current dither control
package sdc_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_HZ       = 40_000_000;                  // system clock rate
  localparam int DITHER_STEP_HZ = 50;                          // frequency step of codes 1 to 10
  localparam int DITHER_HALF_50HZ_CYCLES = CLOCK_HZ / (2 * DITHER_STEP_HZ); // half period at 50 Hz
  localparam int DITHER_HZ_B    = 133;                         // code 1011
  localparam int DITHER_HZ_C    = 166;                         // code 1100
  localparam int DITHER_HZ_D    = 233;                         // code 1101
  localparam int DITHER_HZ_E    = 266;                         // code 1110
  localparam int CNT_W          = 24;                          // dither half-period counter width

  // ------------------------------------------------------------
  // command word layout
  // ------------------------------------------------------------
  localparam int WORD_W       = 16;
  localparam int ADDR_MSB     = 15;
  localparam int ADDR_LSB     = 11;
  localparam int BIT_SELECT10 = 10;                            // pull-up select or retry enable
  localparam int BIT_NINE     = 9;                             // dither off or on/off bit
  localparam int BIT_SWITCH   = 8;                             // regulator one switch mode
  localparam int BIT_THERMAL_LIMIT_FLAG_EN  = 7;
  localparam int AMP_MSB      = 6;
  localparam int AMP_LSB      = 4;
  localparam int FREQ_MSB     = 3;
  localparam int FREQ_LSB     = 0;
  localparam int SET_MSB      = 8;
  localparam int SET_W        = 9;
  localparam int LVL_W        = 10;

  localparam logic [4:0] ADDR_ONE_CTRL = 5'h16;                // 10110
  localparam logic [4:0] ADDR_ONE_FA   = 5'h17;                // 10111
  localparam logic [4:0] ADDR_TWO_CTRL = 5'h18;                // 11000
  localparam logic [4:0] ADDR_TWO_FA   = 5'h19;                // 11001

  localparam logic [3:0] FREQ_OFF  = 4'h0;
  localparam logic [3:0] FREQ_KEEP = 4'hF;

  // ------------------------------------------------------------
  // response word layout
  // ------------------------------------------------------------
  localparam int RSP_SUPPLY    = 15;
  localparam int RSP_RESET     = 14;
  localparam int RSP_TRIM      = 13;
  localparam int RSP_REF       = 12;
  localparam int RSP_OPEN_TWO  = 11;
  localparam int RSP_SHORT_TWO = 10;
  localparam int RSP_OPEN_ONE  = 9;
  localparam int RSP_SHORT_ONE = 8;

  // ------------------------------------------------------------
  // amplitude in converter steps and range limits, reset values
  // ------------------------------------------------------------
  typedef logic [7:0] sdc_amp_t;
  localparam sdc_amp_t AMP_ONE_LSB [0:7] = '{8'h00, 8'h18, 8'h30, 8'h48, 8'h60, 8'h78, 8'h90, 8'hA8};
  localparam sdc_amp_t AMP_TWO_LSB [0:7] = '{8'h00, 8'h30, 8'h48, 8'h60, 8'h78, 8'h90, 8'hA6, 8'hC0};
  localparam logic [9:0] LIMIT_ONE = 10'h200;                  // full scale of regulator one
  localparam logic [9:0] LIMIT_TWO = 10'h200;                  // full scale of regulator two
  localparam logic [8:0] SET_RST   = 9'h000;
  localparam logic [3:0] FREQ_RST  = 4'h0;
  localparam logic [2:0] AMP_RST   = 3'h0;

endpackage : sdc_pkg

// file: sdc_dither_if.sv
// interface carrying one regulator's set-point, dither settings and modulated level
`timescale 1ns/10ps
interface sdc_dither_if;
  logic [8:0] setpoint;   // commanded converter code
  logic       hold;       // dither off
  logic [7:0] amp_lsb;    // pending amplitude in converter steps
  logic [3:0] freq_code;  // pending frequency code
  logic [9:0] limit;      // upper range limit
  logic [9:0] level;      // modulated converter code
  logic       active;     // dither running

  modport ctrl (output setpoint, output hold, output amp_lsb, output freq_code, output limit,
                input level, input active);
  modport unit (input setpoint, input hold, input amp_lsb, input freq_code, input limit,
                output level, output active);
endinterface : sdc_dither_if

// file: sdc_dither.sv
// dither generator: raises and lowers the set-point each half period
`timescale 1ns/10ps
module sdc_dither #(
  parameter int BASE_CYCLES = sdc_pkg::DITHER_HALF_50HZ_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  sdc_dither_if.unit dif
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]                 amp_reg;    // amplitude in use
  logic [3:0]                 freq_reg;   // frequency code in use
  logic [sdc_pkg::CNT_W-1:0]  cnt_reg;    // cycles into half period
  logic                       pos_reg;    // high in positive half
  logic [sdc_pkg::CNT_W-1:0]  half_len;   // cycles per half period
  logic [9:0]                 up_lvl;     // set-point plus amplitude
  logic                       lockout;    // out of range
  logic                       idle;       // nothing to modulate

  // half period lookup
  always_comb begin
    case (freq_reg)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: begin
        half_len = sdc_pkg::CNT_W'(BASE_CYCLES / int'(freq_reg));
      end
      4'hB:    half_len = sdc_pkg::CNT_W'(BASE_CYCLES * 50 / sdc_pkg::DITHER_HZ_B);
      4'hC:    half_len = sdc_pkg::CNT_W'(BASE_CYCLES * 50 / sdc_pkg::DITHER_HZ_C);
      4'hD:    half_len = sdc_pkg::CNT_W'(BASE_CYCLES * 50 / sdc_pkg::DITHER_HZ_D);
      4'hE:    half_len = sdc_pkg::CNT_W'(BASE_CYCLES * 50 / sdc_pkg::DITHER_HZ_E);
      default: half_len = sdc_pkg::CNT_W'(BASE_CYCLES);
    endcase
  end

  // range check against the amplitude actually in use
  assign up_lvl  = {1'b0, dif.setpoint} + {2'b00, amp_reg};
  assign lockout = (up_lvl >= dif.limit) || ({1'b0, dif.setpoint} <= {1'b0, amp_reg});
  assign idle    = dif.hold || (freq_reg == sdc_pkg::FREQ_OFF) || (amp_reg == 8'h00);

  // counter, phase and new settings taken only at a positive start
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      amp_reg  <= 8'h00;
      freq_reg <= sdc_pkg::FREQ_RST;
      cnt_reg  <= '0;
      pos_reg  <= 1'b1;
    end else if (idle) begin
      // stopped: every cycle counts as the start of a positive half
      amp_reg  <= dif.amp_lsb;
      freq_reg <= dif.freq_code;
      cnt_reg  <= '0;
      pos_reg  <= 1'b1;
    end else if (cnt_reg >= half_len - 1'b1) begin
      cnt_reg <= '0;
      pos_reg <= ~pos_reg;
      if (!pos_reg) begin
        amp_reg  <= dif.amp_lsb;
        freq_reg <= dif.freq_code;
      end
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // level follows the phase only while dither is allowed
  assign dif.active = !idle && !lockout;
  assign dif.level  = dif.active ? (pos_reg ? up_lvl : ({1'b0, dif.setpoint} - {2'b00, amp_reg}))
                                 : {1'b0, dif.setpoint};
endmodule : sdc_dither

// file: sdc_hyst.sv
// hysteretic switch control between thresholds five percent around the command
`timescale 1ns/10ps
module sdc_hyst (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [9:0] i_target,
  input  wire logic [9:0] i_sense,
  output logic            o_on
);
  logic [9:0]  band;   // five percent of the command
  logic [10:0] lower;  // turn-on point
  logic [10:0] upper;  // turn-off point
  logic        on_reg; // driver state

  assign band  = i_target / 10'd20;
  assign lower = {1'b0, i_target} - {1'b0, band};
  assign upper = {1'b0, i_target} + {1'b0, band};

  // off until the lower point, on until the upper point
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      on_reg <= 1'b0;
    end else if (!on_reg && ({1'b0, i_sense} <= lower)) begin
      on_reg <= 1'b1;
    end else if (on_reg && ({1'b0, i_sense} >= upper)) begin
      on_reg <= 1'b0;
    end
  end

  assign o_on = on_reg;
endmodule : sdc_hyst

// file: sdc_top.sv
// command decode, dither and switch control for two constant-current regulators
//
// Notes on behaviour
// - switch mode makes regulator one plain on/off
// - frequency code 0 off, 1-10 50 Hz steps
// - codes 11-14 odd rates, 15 keeps previous
// - amplitude code 0 off, 50.4 mA steps
// - control word: pull-up, dither off, 9-bit set-point
// - bit 10 selects pull-down or pull-up source
// - bits 15-11 address, 11000 control, 11001 dither
// - set-point plus amplitude at limit locks dither
// - set-point minus amplitude at zero locks dither
// - dither alternately raises and lowers the set-point
// - new dither settings wait for positive half start
// - hysteretic switching at plus and minus 5%
// - response: bit 15 supply/thermal/cal, 14 reset
// - reset bit flags a power-on reset
// - reference bit: 0 external, 1 internal
// - trim bit: 0 untrimmed, 1 trimmed
// - fault bits clear at chip select rising edge
`timescale 1ns/10ps
module sdc_top #(
  parameter int DITHER_HALF_50HZ_CYCLES = sdc_pkg::DITHER_HALF_50HZ_CYCLES
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_mosi,
  output logic            o_spi_miso,
  output logic            o_spi_miso_oe,
  input  wire logic [9:0] i_sense_one,
  input  wire logic [9:0] i_sense_two,
  input  wire logic       i_supply_fault,
  input  wire logic       i_thermal_fault,
  input  wire logic       i_cal_fault,
  input  wire logic       i_trimmed,
  input  wire logic       i_ref_internal,
  input  wire logic [1:0] i_open_fault,
  input  wire logic [1:0] i_short_fault,
  input  wire logic [7:0] i_out_fault,
  output logic [1:0]      o_drive,
  output logic [9:0]      o_level_one,
  output logic [9:0]      o_level_two,
  output logic [1:0]      o_dither_active,
  output logic [1:0]      o_diag_pullup_select,
  output logic [1:0]      o_retry_en,
  output logic            o_thermal_limit_en,
  output logic            o_regulator_one_switch_mode
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 21;
  logic [NSYNC-1:0] pin_raw;   // every asynchronous input in one vector
  logic [NSYNC-1:0] sync1_reg; // first stage, read only by the second
  logic [NSYNC-1:0] sync2_reg; // second stage, safe to use
  logic             sclk_d_reg; // previous clock level for edge detection
  logic             cs_d_reg;   // previous select level for edge detection

  assign pin_raw = {i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_supply_fault, i_thermal_fault, i_cal_fault,
                    i_trimmed, i_ref_internal, i_open_fault, i_short_fault, i_out_fault, 1'b0};

  // two flip-flops per pin; both stages reset to the idle levels so no false select edge follows reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1_reg <= {2'b01, {(NSYNC-2){1'b0}}};
      sync2_reg <= {2'b01, {(NSYNC-2){1'b0}}};
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic       sclk_s;
  logic       cs_n_s;
  logic       mosi_s;
  logic       supply_s;
  logic       cal_s;
  logic       thermal_s;
  logic       trim_s;
  logic       ref_s;
  logic [1:0] open_s;
  logic [1:0] short_s;
  logic [7:0] outf_s;

  assign sclk_s    = sync2_reg[20];
  assign cs_n_s    = sync2_reg[19];
  assign mosi_s    = sync2_reg[18];
  assign supply_s  = sync2_reg[17];
  assign thermal_s = sync2_reg[16];
  assign cal_s     = sync2_reg[15];
  assign trim_s    = sync2_reg[14];
  assign ref_s     = sync2_reg[13];
  assign open_s    = sync2_reg[12:11];
  assign short_s   = sync2_reg[10:9];
  assign outf_s    = sync2_reg[8:1];

  // edge history taken from the settled stage only
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_n_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s && !sclk_d_reg && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_reg && !cs_n_s;
  assign cs_fall   = !cs_n_s && cs_d_reg;
  assign cs_rise   = cs_n_s && !cs_d_reg;

  // ------------------------------------------------------------
  // serial shift and frame
  // ------------------------------------------------------------
  logic [15:0] rx_reg;   // command bits, first bit ends up at the top
  logic [15:0] tx_reg;   // response bits, top bit on the line
  logic [4:0]  bits_reg; // bits taken in this frame
  logic [15:0] status;   // response built from the sticky flags

  // sample on the rising clock edge, shift the response after the falling edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx_reg   <= 16'h0000;
      tx_reg   <= 16'h0000;
      bits_reg <= 5'h00;
    end else if (cs_fall) begin
      bits_reg <= 5'h00;
      tx_reg   <= status;
    end else begin
      if (sclk_rise) begin
        rx_reg <= {rx_reg[14:0], mosi_s};
        if (bits_reg != 5'h1F) begin
          bits_reg <= bits_reg + 5'h01;
        end
      end
      if (sclk_fall) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // driven only while selected
  assign o_spi_miso    = tx_reg[15];
  assign o_spi_miso_oe = !cs_n_s;

  // only whole sixteen-bit words are acted on
  logic       word_ok;
  logic [4:0] addr;
  assign word_ok = cs_rise && (bits_reg == 5'(sdc_pkg::WORD_W));
  assign addr    = rx_reg[sdc_pkg::ADDR_MSB:sdc_pkg::ADDR_LSB];

  // ------------------------------------------------------------
  // fault and status flags
  // ------------------------------------------------------------
  logic       supply_flt_reg; // over-voltage, thermal limit or calibration
  logic       reset_flt_reg;  // power-on reset seen
  logic [1:0] open_flt_reg;
  logic [1:0] short_flt_reg;
  logic [7:0] out_flt_reg;

  // sticky faults; a fault present at the clearing edge stays set
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      supply_flt_reg <= 1'b0;
      reset_flt_reg  <= 1'b1;
      open_flt_reg   <= 2'b00;
      short_flt_reg  <= 2'b00;
      out_flt_reg    <= 8'h00;
    end else if (cs_rise) begin
      supply_flt_reg <= supply_s || thermal_s || cal_s;
      reset_flt_reg  <= 1'b0;
      open_flt_reg   <= open_s;
      short_flt_reg  <= short_s;
      out_flt_reg    <= outf_s;
    end else begin
      supply_flt_reg <= supply_flt_reg | supply_s | thermal_s | cal_s;
      open_flt_reg   <= open_flt_reg | open_s;
      short_flt_reg  <= short_flt_reg | short_s;
      out_flt_reg    <= out_flt_reg | outf_s;
    end
  end

  // trim and reference bits are levels, not faults
  always_comb begin
    status                         = {8'h00, out_flt_reg};
    status[sdc_pkg::RSP_SUPPLY]    = supply_flt_reg;
    status[sdc_pkg::RSP_RESET]     = reset_flt_reg;
    status[sdc_pkg::RSP_TRIM]      = trim_s;
    status[sdc_pkg::RSP_REF]       = ref_s;
    status[sdc_pkg::RSP_OPEN_TWO]  = open_flt_reg[1];
    status[sdc_pkg::RSP_SHORT_TWO] = short_flt_reg[1];
    status[sdc_pkg::RSP_OPEN_ONE]  = open_flt_reg[0];
    status[sdc_pkg::RSP_SHORT_ONE] = short_flt_reg[0];
  end

  // ------------------------------------------------------------
  // command registers
  // ------------------------------------------------------------
  logic [8:0] set_reg   [2];  // set-point per regulator
  logic [1:0] hold_reg;       // dither off per regulator
  logic [2:0] amp_reg   [2];  // pending amplitude code
  logic [3:0] freq_reg  [2];  // pending frequency code
  logic [1:0] pullup_reg;     // diagnostic source select
  logic [1:0] retry_reg;      // retry enable
  logic       onoff_reg;      // on/off bit of regulator one
  logic       swmode_reg;     // regulator one as plain switch
  logic       thermal_limit_flag_reg;       // thermal limit enable

  // address decode; only the four regulator commands touch these
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      set_reg    <= '{sdc_pkg::SET_RST, sdc_pkg::SET_RST};
      hold_reg   <= 2'b00;
      amp_reg    <= '{sdc_pkg::AMP_RST, sdc_pkg::AMP_RST};
      freq_reg   <= '{sdc_pkg::FREQ_RST, sdc_pkg::FREQ_RST};
      pullup_reg <= 2'b00;
      retry_reg  <= 2'b00;
      onoff_reg  <= 1'b0;
      swmode_reg <= 1'b0;
      thermal_limit_flag_reg   <= 1'b0;
    end else if (word_ok) begin
      case (addr)
        sdc_pkg::ADDR_ONE_CTRL, sdc_pkg::ADDR_TWO_CTRL: begin
          set_reg[addr[3]]    <= rx_reg[sdc_pkg::SET_MSB:0];
          hold_reg[addr[3]]   <= rx_reg[sdc_pkg::BIT_NINE];
          pullup_reg[addr[3]] <= rx_reg[sdc_pkg::BIT_SELECT10];
        end
        sdc_pkg::ADDR_ONE_FA, sdc_pkg::ADDR_TWO_FA: begin
          retry_reg[addr[3]] <= rx_reg[sdc_pkg::BIT_SELECT10];
          amp_reg[addr[3]]   <= rx_reg[sdc_pkg::AMP_MSB:sdc_pkg::AMP_LSB];
          if (rx_reg[sdc_pkg::FREQ_MSB:sdc_pkg::FREQ_LSB] != sdc_pkg::FREQ_KEEP) begin
            freq_reg[addr[3]] <= rx_reg[sdc_pkg::FREQ_MSB:sdc_pkg::FREQ_LSB];
          end
          if (!addr[3]) begin
            onoff_reg  <= rx_reg[sdc_pkg::BIT_NINE];
            swmode_reg <= rx_reg[sdc_pkg::BIT_SWITCH];
            thermal_limit_flag_reg   <= rx_reg[sdc_pkg::BIT_THERMAL_LIMIT_FLAG_EN];
          end
        end
        default: begin
          // other addresses belong to other blocks
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // per-regulator dither and switch control
  // ------------------------------------------------------------
  sdc_dither_if dif [2] ();
  logic [9:0] level [2]; // modulated converter code
  logic [1:0] hyst_on;   // switch control decision
  logic [1:0] active;    // dither running
  logic [9:0] sense [2];
  assign sense[0] = i_sense_one;
  assign sense[1] = i_sense_two;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_reg
      // amplitude codes map to converter steps per regulator
      assign dif[ch].setpoint  = set_reg[ch];
      assign dif[ch].hold      = hold_reg[ch];
      assign dif[ch].amp_lsb   = (ch == 0) ? sdc_pkg::AMP_ONE_LSB[amp_reg[ch]]
                                           : sdc_pkg::AMP_TWO_LSB[amp_reg[ch]];
      assign dif[ch].freq_code = freq_reg[ch];
      assign dif[ch].limit     = (ch == 0) ? sdc_pkg::LIMIT_ONE : sdc_pkg::LIMIT_TWO;
      assign level[ch]         = dif[ch].level;
      assign active[ch]        = dif[ch].active;

      sdc_dither #(
        .BASE_CYCLES (DITHER_HALF_50HZ_CYCLES)
      ) u_dither (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .dif     (dif[ch])
      );

      sdc_hyst u_hyst (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_target (level[ch]),
        .i_sense  (sense[ch]),
        .o_on     (hyst_on[ch])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // outputs, registered so the drivers never see decode glitches
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_drive         <= 2'b00;
      o_level_one     <= 10'h000;
      o_level_two     <= 10'h000;
      o_dither_active <= 2'b00;
    end else begin
      o_drive[0]      <= swmode_reg ? onoff_reg : hyst_on[0];
      o_drive[1]      <= hyst_on[1];
      o_level_one     <= level[0];
      o_level_two     <= level[1];
      o_dither_active <= swmode_reg ? {active[1], 1'b0} : active;
    end
  end

  assign o_diag_pullup_select        = pullup_reg;
  assign o_retry_en                  = retry_reg;
  assign o_thermal_limit_en          = thermal_limit_flag_reg;
  assign o_regulator_one_switch_mode = swmode_reg;

endmodule : sdc_top

// file: sdc_asserts.sv
// port-level checks on the dither control
`timescale 1ns/10ps
module sdc_asserts #(
  parameter int DITHER_HALF_50HZ_CYCLES = 100
) (
  input wire logic       i_clock, i_rst_n, i_spi_cs_n, o_spi_miso_oe, o_regulator_one_switch_mode,
  input wire logic [9:0] i_sense_two, o_level_two,
  input wire logic [1:0] o_drive, o_dither_active
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0]  idle_reg;  // cycles since select was last low
  logic [23:0] run_reg;   // cycles the dithered level has stood still
  // steadiness judged only well after select
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !i_spi_cs_n) idle_reg <= 8'h00;
    else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !o_dither_active[1] || !$stable(o_level_two)) run_reg <= '0;
    else if (run_reg != '1) run_reg <= run_reg + 24'h1;
  end
  AST_OE_ON: assert property ($fell(i_spi_cs_n) |-> ##[1:4] o_spi_miso_oe)
    else $error("reply not enabled after select");
  AST_OE_OFF: assert property (i_spi_cs_n [*5] |-> !o_spi_miso_oe)
    else $error("reply enabled while not selected");
  AST_SWITCH_NO_DITHER: assert property (o_regulator_one_switch_mode |-> !o_dither_active[0])
    else $error("dither running in switch mode");
  AST_RANGE: assert property (o_dither_active[1] [*3] |-> o_level_two < 10'h200 && o_level_two != 10'h000)
    else $error("dithered level out of range");
  AST_DRIVE_ON: assert property ((i_sense_two == 10'h000 && o_level_two != 10'h000) [*3] |-> o_drive[1])
    else $error("driver off below lower threshold");
  AST_DRIVE_OFF: assert property ((i_sense_two == 10'h3FF) [*3] |-> !o_drive[1])
    else $error("driver on above upper threshold");
  AST_HALF_BOUND: assert property (o_dither_active[1] |-> run_reg <= 24'(DITHER_HALF_50HZ_CYCLES + 2))
    else $error("dithered level stuck too long");
  AST_HOLD_STEADY: assert property ((idle_reg > 8'h0C && !o_dither_active[1]) [*3] |-> $stable(o_level_two))
    else $error("level moved without dither");
  cover property (o_dither_active[1] ##1 !$stable(o_level_two));
  cover property (o_regulator_one_switch_mode && o_drive[0]);
  cover property ($fell(o_dither_active[1]));
endmodule : sdc_asserts

// file: sdc_spi_master.sv
// spi master model: sends one word msb first and collects the reply
`timescale 1ns/10ps
module sdc_spi_master (
  input  wire logic   i_clock,
  input  wire logic   i_miso,
  output logic        o_sclk, o_cs_n, o_mosi, o_done,
  output logic [15:0] o_rsp
);
  initial {o_sclk, o_cs_n, o_mosi, o_done, o_rsp} = 20'h40000;
  // four clocks a phase; only whole words report
  task automatic xfer(input logic [15:0] w, input int n);
    logic [15:0] r;
    r = 16'h0000;
    @(posedge i_clock) o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_mosi <= w[15-i];
      repeat (4) @(posedge i_clock);
      r = {r[14:0], i_miso};
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clock);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;  // released line must not keep the last bit
    o_rsp  <= r;
    o_done <= (n == 16);
    @(posedge i_clock) o_done <= 1'b0;
    repeat (5) @(posedge i_clock);
  endtask : xfer
endmodule : sdc_spi_master

// file: tb_solenoid_current_dither_control.sv
// self-checking bench for the dither control
`timescale 1ns/10ps
module tb_solenoid_current_dither_control;
  localparam int HALF = 100;  // shortened 50 Hz half period
  localparam int FHZ [4] = '{sdc_pkg::DITHER_HZ_B, sdc_pkg::DITHER_HZ_C, sdc_pkg::DITHER_HZ_D, sdc_pkg::DITHER_HZ_E};
  localparam logic [8:0] SETS [4] = '{9'h1D0, 9'h1CF, 9'h030, 9'h031};
  logic        i_clock, i_rst_n, sclk, cs_n, mosi, miso, done, sf, tf, cfl, trm, rfi, thermal_limit_flag, swm, rst_f;
  logic [1:0]  opn, sht, drive, act, pu, retry;
  logic [7:0]  outf;
  logic [9:0]  s1, s2, lvl2;
  logic [12:0] pf;
  logic [15:0] rsp, exp_q [$];
  int          errors, total_checks, cyc, a;
  int          seed = 40;
  sdc_top #(.DITHER_HALF_50HZ_CYCLES(HALF)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(), .i_sense_one(s1), .i_sense_two(s2),
    .i_supply_fault(sf), .i_thermal_fault(tf), .i_cal_fault(cfl), .i_trimmed(trm), .i_ref_internal(rfi),
    .i_open_fault(opn), .i_short_fault(sht), .i_out_fault(outf), .o_drive(drive), .o_level_one(),
    .o_level_two(lvl2), .o_dither_active(act), .o_diag_pullup_select(pu), .o_retry_en(retry),
    .o_thermal_limit_en(thermal_limit_flag), .o_regulator_one_switch_mode(swm));
  sdc_spi_master m (.i_clock(i_clock), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .o_done(done), .o_rsp(rsp));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // hang guard and sense stimulus
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 0) {s2, s1} <= {{10{1'($random(seed))}}, 10'($random(seed))};
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  // reply watcher
  always @(posedge done) begin
    #1;
    cmp(rsp, exp_q.pop_front());
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  // sticky faults show old and new levels
  task automatic send(input logic [15:0] w, input int n);
    logic [12:0] c;
    c = {sf | tf | cfl, opn[1], sht[1], opn[0], sht[0], outf};
    if (n == 16) exp_q.push_back({pf[12] | c[12], rst_f, trm, rfi, pf[11:0] | c[11:0]});
    m.xfer(w, n);
    pf = c;
    rst_f = 1'b0;
    repeat (4) @(posedge i_clock);
  endtask : send
  // times one settled half
  task automatic measure(input int h, input logic [9:0] hi, input logic [9:0] lo);
    logic [9:0] v;
    int         t;
    for (int k = 0; k < 5; k++) begin
      v = lvl2;
      t = 0;
      while (lvl2 === v && t < 1000) begin
        @(posedge i_clock);
        #1;
        t++;
      end
    end
    cmp({15'h0000, t >= h - 1 && t <= h + 1}, 16'h0001);
    cmp({15'h0000, (v === hi && lvl2 === lo) || (v === lo && lvl2 === hi)}, 16'h0001);
  endtask : measure
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {i_rst_n, sf, tf, cfl, trm, rfi, opn, sht, outf, s1, s2} = 38'h0;
    rst_f = 1'b1;
    pf = 13'h0000;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    for (int k = 0; k < 6; k++) begin
      send(16'h0000, 16);
      @(posedge i_clock) {sf, tf, cfl, trm, rfi, opn, sht, outf} <= 17'($random(seed));
      repeat (4) @(posedge i_clock);
    end
    $display("reply status test done");
    for (int p = 0; p < 2; p++) begin
      send({sdc_pkg::ADDR_TWO_CTRL, p[0], 1'b1, 9'h0A0}, 16);
      cmp({4'h0, pu[1], act[1], lvl2}, {4'h0, p[0], 1'b0, 10'h0A0});
    end
    send({sdc_pkg::ADDR_TWO_CTRL, 1'b0, 1'b1, 9'h0A0}, 15);
    cmp({15'h0000, pu[1]}, 16'h0001);
    send({sdc_pkg::ADDR_TWO_FA, 1'b1, 10'h000}, 16);
    cmp({15'h0000, retry[1]}, 16'h0001);
    for (int on = 0; on < 2; on++) begin
      send({sdc_pkg::ADDR_ONE_FA, 1'b1, on[0], 1'b1, 1'b1, 3'h2, 4'h3}, 16);
      cmp({11'h000, swm, thermal_limit_flag, retry[0], act[0], drive[0]}, {11'h000, 3'h7, 1'b0, on[0]});
    end
    $display("command decode test done");
    send({sdc_pkg::ADDR_TWO_CTRL, 2'b00, 9'h100}, 16);
    for (int c = 1; c < 16; c++) begin
      a = 1 + c % 7;
      send({sdc_pkg::ADDR_TWO_FA, 4'h0, a[2:0], c[3:0]}, 16);
      measure((c <= 10) ? HALF / c : HALF * 50 / FHZ[(c > 14) ? 3 : c - 11],
        10'h100 + sdc_pkg::AMP_TWO_LSB[a], 10'h100 - sdc_pkg::AMP_TWO_LSB[a]);
    end
    send({sdc_pkg::ADDR_TWO_FA, 11'h000}, 16);
    repeat (100) @(posedge i_clock);
    cmp({5'h00, act[1], lvl2}, {6'h00, 10'h100});
    send({sdc_pkg::ADDR_TWO_FA, 4'h0, 3'h1, 4'h1}, 16);
    foreach (SETS[i]) begin
      send({sdc_pkg::ADDR_TWO_CTRL, 2'b00, SETS[i]}, 16);
      repeat (250) @(posedge i_clock);
      cmp({15'h0000, act[1]}, {15'h0000, i[0]});
    end
    $display("dither test done");
    report_and_stop();
  end
endmodule : tb_solenoid_current_dither_control
bind sdc_top sdc_asserts #(.DITHER_HALF_50HZ_CYCLES(DITHER_HALF_50HZ_CYCLES)) u_chk (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n), .o_spi_miso_oe(o_spi_miso_oe), .i_sense_two(i_sense_two),
  .o_regulator_one_switch_mode(o_regulator_one_switch_mode), .o_level_two(o_level_two), .o_drive(o_drive),
  .o_dither_active(o_dither_active));
